// file: rtl/pca_top.v
// Programmable counter array with five capture/compare modules on AXI4-Lite
`include "pca_map.vh"
`default_nettype none
module pca_top #(
  parameter NMOD = 5,
  parameter WD_INDEX = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_idle,
  input wire timer0_overflow,
  input wire external_count_input,
  input wire ext_osc_div8,
  input wire [4:0] module_line_in,
  output wire [4:0] module_line_out,
  output wire [4:0] module_line_oe,
  output wire irq,
  output reg watchdog_reset
);
  // ***************
  // Pin synchronisers
  // ***************
  reg [6:0] sync_a;
  reg [6:0] sync_b;
  reg eci_prev;
  reg osc_prev;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
      eci_prev <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      sync_a <= {ext_osc_div8, external_count_input, module_line_in};
      sync_b <= sync_a;
      eci_prev <= sync_b[5];
      osc_prev <= sync_b[6];
    end
  end
  // ***************
  // Registers
  // ***************
  reg [7:0] amode;
  reg run_bit;
  reg ovf;
  reg [15:0] count;
  reg [7:0] snap;
  reg gie;
  reg aie;
  reg wd_lock;
  reg [3:0] div_cnt;
  wire wd_on = amode[`PCA_MODE_WDE] | wd_lock;
  wire running = run_bit | wd_on;
  wire suspended = amode[`PCA_MODE_IDLE] & cpu_idle;
  wire [2:0] tb = amode[`PCA_MODE_TB_HI:`PCA_MODE_TB_LO];
  reg src;
  always @* begin
    case (tb)
      `PCA_TB_DIV12: src = div_cnt == `PCA_DIV12;
      `PCA_TB_DIV4: src = div_cnt == `PCA_DIV4;
      `PCA_TB_T0: src = timer0_overflow;
      `PCA_TB_EXT: src = eci_prev & ~sync_b[5];
      `PCA_TB_SYS: src = 1'b1;
      `PCA_TB_OSC8: src = ~osc_prev & sync_b[6];
      default: src = 1'b0;
    endcase
  end
  wire tick = src & running & ~suspended;
  // ***************
  // Bus slave, one transaction each way at a time
  // ***************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire wr_lane = wr_go & w_strb[0];
  wire [7:0] wb = w_data[7:0];
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire [7:0] rmod = s_axi_araddr - `PCA_MOD_BASE;
  wire [7:0] wmod = aw_addr - `PCA_MOD_BASE;
  wire w_is_mod = aw_addr >= `PCA_MOD_BASE && wmod < NMOD * `PCA_MOD_STRIDE;
  wire r_is_mod = s_axi_araddr >= `PCA_MOD_BASE && rmod < NMOD * `PCA_MOD_STRIDE;
  wire w_ctrl = wr_lane && aw_addr == `PCA_CTRL_ADDR;
  // ***************
  // Modules
  // ***************
  wire [8*NMOD-1:0] m_mode;
  wire [8*NMOD-1:0] m_low;
  wire [8*NMOD-1:0] m_high;
  wire [NMOD-1:0] m_flag;
  wire [NMOD-1:0] m_exp;
  genvar g;
  generate
    for (g = 0; g < NMOD; g = g + 1) begin : mods
      wire hit = wr_lane && w_is_mod && wmod[7:4] == g;
      pca_module #(.WD(g == WD_INDEX)) u_mod (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .count(count),
        .line_sync(sync_b[g]),
        .wd_on(wd_on),
        .mode_wdata(wb),
        .mode_we(hit && wmod[3:0] == `PCA_MOD_MODE_OFS),
        .byte_wdata(wb),
        .low_we(hit && wmod[3:0] == `PCA_MOD_LOW_OFS),
        .high_we(hit && wmod[3:0] == `PCA_MOD_HIGH_OFS),
        .flag_set_sw(w_ctrl && wb[g] && !(g == WD_INDEX && wd_on)),
        .flag_clr_sw(w_ctrl && !wb[g]),
        .mode(m_mode[8*g+7:8*g]),
        .low_byte(m_low[8*g+7:8*g]),
        .high_byte(m_high[8*g+7:8*g]),
        .flag(m_flag[g]),
        .line_out(module_line_out[g]),
        .wd_expire(m_exp[g])
      );
      // Line is driven whenever the CMP bit is set, capture modes included
      assign module_line_oe[g] = m_mode[8*g+`PCA_MM_CMP];
    end
  endgenerate
  wire [NMOD-1:0] mod_ie;
  generate
    for (g = 0; g < NMOD; g = g + 1) begin : ies
      assign mod_ie[g] = m_mode[8*g+`PCA_MM_IE];
    end
  endgenerate
  wire any_req = (ovf & amode[`PCA_MODE_OVIE]) | (|(m_flag & mod_ie));
  assign irq = gie & aie & any_req;
  // ***************
  // Counter, control and bus state
  // ***************
  always @(posedge aclk) begin
    if (!aresetn) begin
      amode <= `PCA_MODE_RESET;
      run_bit <= 1'b0;
      ovf <= 1'b0;
      count <= 16'h0000;
      snap <= 8'h00;
      gie <= 1'b0;
      aie <= 1'b0;
      wd_lock <= 1'b0;
      div_cnt <= 4'h0;
      watchdog_reset <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
    end else begin
      // Prescaler wraps at the divide-by-12 count, or at the divide-by-4 count when that timebase is selected
      if (tb == `PCA_TB_DIV4 && div_cnt == `PCA_DIV4 || div_cnt == `PCA_DIV12) begin
        div_cnt <= 4'h0;
      end else if (!suspended) begin
        div_cnt <= div_cnt + 4'h1;
      end
      watchdog_reset <= |m_exp || (w_ctrl && wb[WD_INDEX] && wd_on);
      if (tick) begin
        count <= count + 16'h0001;
      end
      if (w_ctrl && !wb[`PCA_CTRL_OVF]) begin
        ovf <= 1'b0;
      end
      if (tick && count == 16'hffff) begin
        ovf <= 1'b1;
      end
      if (w_ctrl) begin
        run_bit <= wb[`PCA_CTRL_RUN];
      end
      if (wr_lane && aw_addr == `PCA_MODE_ADDR) begin
        amode[`PCA_MODE_WDE] <= wb[`PCA_MODE_WDE];
        amode[`PCA_MODE_OVIE] <= wb[`PCA_MODE_OVIE];
        if (wb[`PCA_MODE_WDL]) begin
          wd_lock <= 1'b1;
        end
        if (!wd_on) begin
          amode[`PCA_MODE_IDLE] <= wb[`PCA_MODE_IDLE];
          amode[`PCA_MODE_TB_HI:`PCA_MODE_TB_LO] <= wb[`PCA_MODE_TB_HI:`PCA_MODE_TB_LO];
        end
      end
      if (wr_lane && !wd_on && aw_addr == `PCA_CNTL_ADDR) begin
        count[7:0] <= wb;
      end
      if (wr_lane && !wd_on && aw_addr == `PCA_CNTH_ADDR) begin
        count[15:8] <= wb;
      end
      if (wr_lane && aw_addr == `PCA_IRQ_ADDR) begin
        gie <= wb[`PCA_IRQ_GLOBAL];
        aie <= wb[`PCA_IRQ_ARRAY];
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= `PCA_IRQ_ADDR || w_is_mod) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          `PCA_CTRL_ADDR: s_axi_rdata[7:0] <= {ovf, run_bit, 1'b0, m_flag};
          `PCA_MODE_ADDR: s_axi_rdata[7:0] <= {amode[7:6], wd_lock, amode[4:0]};
          `PCA_CNTL_ADDR: begin
            s_axi_rdata[7:0] <= count[7:0];
            snap <= count[15:8];
          end
          `PCA_CNTH_ADDR: s_axi_rdata[7:0] <= snap;
          `PCA_IRQ_ADDR: s_axi_rdata[1:0] <= {gie, aie};
          default: begin
            if (r_is_mod && rmod[3:0] == `PCA_MOD_MODE_OFS) begin
              s_axi_rdata[7:0] <= m_mode[8*rmod[7:4] +: 8];
            end else if (r_is_mod && rmod[3:0] == `PCA_MOD_LOW_OFS) begin
              s_axi_rdata[7:0] <= m_low[8*rmod[7:4] +: 8];
            end else if (r_is_mod && rmod[3:0] == `PCA_MOD_HIGH_OFS) begin
              s_axi_rdata[7:0] <= m_high[8*rmod[7:4] +: 8];
            end else begin
              s_axi_rresp <= 2'b10;
            end
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/pca_map.vh
// Register map, field positions and reset values of the counter array
`ifndef PCA_MAP_VH
`define PCA_MAP_VH
// ***************
// Byte addresses
// ***************
`define PCA_CTRL_ADDR 8'h00
`define PCA_MODE_ADDR 8'h04
`define PCA_CNTL_ADDR 8'h08
`define PCA_CNTH_ADDR 8'h0c
`define PCA_IRQ_ADDR 8'h10
`define PCA_MOD_BASE 8'h20
`define PCA_MOD_STRIDE 8'h10
`define PCA_MOD_MODE_OFS 4'h0
`define PCA_MOD_LOW_OFS 4'h4
`define PCA_MOD_HIGH_OFS 4'h8
// ***************
// Control register fields
// ***************
`define PCA_CTRL_OVF 7
`define PCA_CTRL_RUN 6
// ***************
// Array mode register fields
// ***************
`define PCA_MODE_IDLE 7
`define PCA_MODE_WDE 6
`define PCA_MODE_WDL 5
`define PCA_MODE_TB_HI 3
`define PCA_MODE_TB_LO 1
`define PCA_MODE_OVIE 0
`define PCA_MODE_RESET 8'h40
// ***************
// Module mode register fields
// ***************
`define PCA_MM_WIDE 7
`define PCA_MM_CMP 6
`define PCA_MM_RISE 5
`define PCA_MM_FALL 4
`define PCA_MM_MAT 3
`define PCA_MM_TOG 2
`define PCA_MM_PWM 1
`define PCA_MM_IE 0
// ***************
// Interrupt enable register fields
// ***************
`define PCA_IRQ_GLOBAL 1
`define PCA_IRQ_ARRAY 0
// ***************
// Timebase codes and divisors
// ***************
`define PCA_TB_DIV12 3'h0
`define PCA_TB_DIV4 3'h1
`define PCA_TB_T0 3'h2
`define PCA_TB_EXT 3'h3
`define PCA_TB_SYS 3'h4
`define PCA_TB_OSC8 3'h5
`define PCA_DIV12 4'hb
`define PCA_DIV4 4'h3
`endif

// file: rtl/pca_module.v
// One capture/compare module of the counter array
`include "pca_map.vh"
`default_nettype none
module pca_module #(
  parameter WD = 0
) (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire [15:0] count,
  input wire line_sync,
  input wire wd_on,
  input wire [7:0] mode_wdata,
  input wire mode_we,
  input wire [7:0] byte_wdata,
  input wire low_we,
  input wire high_we,
  input wire flag_set_sw,
  input wire flag_clr_sw,
  output reg [7:0] mode,
  output reg [7:0] low_byte,
  output reg [7:0] high_byte,
  output reg flag,
  output reg line_out,
  output wire wd_expire
);
  reg line_prev;
  wire cap_sel = ~mode[`PCA_MM_TOG] & ~mode[`PCA_MM_MAT] & ~mode[`PCA_MM_PWM];
  wire rise = line_sync & ~line_prev;
  wire fall = ~line_sync & line_prev;
  wire cap_hit = cap_sel & ((mode[`PCA_MM_RISE] & rise) | (mode[`PCA_MM_FALL] & fall));
  wire full_eq = count == {high_byte, low_byte};
  wire cmp_on = mode[`PCA_MM_CMP] & ~mode[`PCA_MM_RISE] & ~mode[`PCA_MM_FALL];
  wire timer_m = cmp_on & mode[`PCA_MM_MAT] & ~mode[`PCA_MM_PWM];
  wire hso_m = timer_m & mode[`PCA_MM_TOG];
  wire freq_m = cmp_on & mode[`PCA_MM_TOG] & mode[`PCA_MM_PWM];
  wire pwm_m = cmp_on & ~mode[`PCA_MM_TOG] & mode[`PCA_MM_PWM];
  wire wide_modulation_select = pwm_m & mode[`PCA_MM_WIDE];
  wire low_eq = count[7:0] == low_byte;
  wire low_wrap = count[7:0] == 8'hff;
  wire full_wrap = count == 16'hffff;
  // Expiry when the low byte wraps while the high bytes agree
  assign wd_expire = (WD != 0) & wd_on & tick & low_wrap & (high_byte == count[15:8]);
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode <= 8'h00;
      low_byte <= 8'h00;
      high_byte <= 8'h00;
      flag <= 1'b0;
      line_out <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      line_prev <= line_sync;
      if (mode_we && !((WD != 0) && wd_on)) begin
        mode <= mode_wdata;
      end
      if (low_we) begin
        low_byte <= byte_wdata;
        mode[`PCA_MM_CMP] <= 1'b0;
      end
      if (high_we) begin
        if ((WD != 0) && wd_on) begin
          high_byte <= count[15:8] + low_byte;
        end else begin
          high_byte <= byte_wdata;
          mode[`PCA_MM_CMP] <= 1'b1;
        end
      end
      if (cap_hit && !((WD != 0) && wd_on)) begin
        {high_byte, low_byte} <= count;
      end
      if (tick && !((WD != 0) && wd_on)) begin
        if (hso_m && full_eq) begin
          line_out <= ~line_out;
        end
        if (freq_m && low_eq) begin
          line_out <= ~line_out;
          low_byte <= low_byte + high_byte;
        end
        if (pwm_m && !wide_modulation_select && low_eq) begin
          line_out <= 1'b1;
        end
        if (pwm_m && !wide_modulation_select && low_wrap) begin
          line_out <= 1'b0;
          low_byte <= high_byte;
        end
        if (wide_modulation_select && full_eq) begin
          line_out <= 1'b1;
        end
        if (wide_modulation_select && full_wrap) begin
          line_out <= 1'b0;
        end
      end
      // Hardware set wins over a software clear in the same cycle
      if (flag_clr_sw) begin
        flag <= 1'b0;
      end
      if (flag_set_sw) begin
        flag <= 1'b1;
      end
      if ((cap_hit && !((WD != 0) && wd_on)) ||
          (tick && !((WD != 0) && wd_on) && cmp_on && mode[`PCA_MM_MAT] && full_eq)) begin
        flag <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/pca_pins.sv
// Pin-side model: capture sources and count inputs of the counter array
`default_nettype none
module pca_pins (
  input wire logic aclk,
  input wire logic [4:0] want,
  input wire logic ext_run,
  input wire logic [4:0] module_line_out,
  input wire logic [4:0] module_line_oe,
  output logic [4:0] module_line_in,
  output logic external_count_input,
  output logic ext_osc_div8
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] drv = 5'h00;
  logic [1:0] held [5] = '{default: 2'h0};
  logic [2:0] ph = 3'h0;
  // ****************
  // Line sources
  // ****************
  // Slow sources: each level is held for at least three clocks before it may change
  always @(posedge aclk) begin
    ph <= ph + 3'h1;
    for (int n = 0; n < 5; n++) begin
      if (held[n] < 2'h2) begin
        held[n] <= held[n] + 2'h1;
      end else if (drv[n] != want[n]) begin
        drv[n] <= want[n];
        held[n] <= 2'h0;
      end
    end
  end
  // Falls every fourth clock, half the fastest rate still counted
  assign external_count_input = ext_run & ph[1];
  assign ext_osc_div8 = ph[2];
  // Shared pin: a driving module wins over the source
  assign module_line_in = (module_line_oe & module_line_out) | (~module_line_oe & drv);
endmodule
`default_nettype wire

// file: test/pca_chk.sv
// Port checker of the counter array
`default_nettype none
module pca_chk #(
  parameter NMOD = 5,
  parameter WD_INDEX = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic watchdog_reset,
  input wire logic [4:0] module_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_quiet_a: assert property (disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
    && !irq && !watchdog_reset && module_line_out == 5'h00) else $error("outputs live in reset");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overtaken");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write overtaken");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14
    |=> s_axi_rresp == 2'h2) else $error("unmapped read accepted");
  byte_wide_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:8]
    == 24'h0) else $error("upper read bits set");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (irq);
  cover property (watchdog_reset);
endmodule
bind pca_top pca_chk #(.NMOD(NMOD), .WD_INDEX(WD_INDEX)) chk_i (.*);
`default_nettype wire

// file: test/test_programmable_counter_array.sv
// Self-checking bench of the counter array
`default_nettype none
module test_programmable_counter_array;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cpu_idle = 1'h0, timer0_overflow = 1'h0, ext_run = 1'h1;
  logic external_count_input, ext_osc_div8, irq, watchdog_reset;
  logic [4:0] module_line_in, module_line_out, module_line_oe, want = 5'h00;
  logic [31:0] seed = 32'h0001_0881;
  logic wd_seen = 1'h0;
  logic [34:0] rq[$];
  logic [1:0] wq[$];
  int fail_count = 0, samples_checked = 0;
  always #25 aclk = ~aclk;
  pca_top #(.NMOD(5), .WD_INDEX(4)) DUT (.*);
  pca_pins pins (.*);
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d, wrong %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Holds each channel until its own handshake edge, ready sampled at mid-cycle
  task automatic hs(input bit r);
    int n;
    bit a, b, c;
    n = 0;
    // Request lands by non-blocking assignment, so test the loop only after one pass
    do begin
      @(negedge aclk);
      a = r ? s_axi_arvalid && s_axi_arready : s_axi_awvalid && s_axi_awready;
      b = r ? s_axi_rvalid && s_axi_rready : s_axi_wvalid && s_axi_wready;
      c = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (r && a) s_axi_arvalid <= 1'h0;
      if (r && b) s_axi_rready <= 1'h0;
      if (!r && a) s_axi_awvalid <= 1'h0;
      if (!r && b) s_axi_wvalid <= 1'h0;
      if (!r && c) s_axi_bready <= 1'h0;
      n++;
      if (n > 100) begin
        fail_count++;
        complete_run();
      end
    end while (r ? (s_axi_arvalid || s_axi_rready)
        : (s_axi_awvalid || s_axi_wvalid || s_axi_bready));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wq.push_back(a == 8'h14 ? 2'h2 : 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    hs(0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({a != 8'h14, a == 8'h14 ? 2'h2 : 2'h0, 24'h0, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    hs(1);
  endtask
  // ****************
  // Result monitor
  // ****************
  always @(negedge aclk) begin
    logic [34:0] e;
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk("read response", e[33:32], s_axi_rresp);
      if (e[34]) chk("read data", e[31:0], s_axi_rdata);
    end
    if (s_axi_bvalid && s_axi_bready) chk("write response", wq.pop_front(), s_axi_bresp);
  end
  always @(posedge aclk) if (watchdog_reset === 1'h1) wd_seen <= 1'h1;
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [31:0] v;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h04, 8'h40);
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h5a);
    wr(8'h04, 8'h48);
    rd(8'h04, 8'h40);
    chk("watchdog reset", 1'h0, wd_seen);
    wr(8'h00, 8'h10);
    repeat (4) @(posedge aclk);
    chk("watchdog reset", 1'h1, wd_seen);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'h08);
    // Rising, falling and both-edge capture on a stopped count
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      wr(8'h00, 8'h00);
      wr(8'h20, 8'h00);
      want <= (i == 1) ? 5'h01 : 5'h00;
      wr(8'h08, v[7:0]);
      wr(8'h0c, v[15:8]);
      wr(8'h20, i == 0 ? 8'h20 : i == 1 ? 8'h10 : 8'h30);
      want <= (i == 1) ? 5'h00 : 5'h01;
      repeat (8) @(posedge aclk);
      rd(8'h24, v[7:0]);
      rd(8'h28, v[15:8]);
      rd(8'h00, 8'h01);
    end
    // A high write after the low read must not reach the snapshot
    v = rnd();
    wr(8'h08, v[7:0]);
    wr(8'h0c, v[15:8]);
    rd(8'h08, v[7:0]);
    wr(8'h0c, ~v[15:8]);
    rd(8'h0c, v[15:8]);
    wr(8'h08, 8'hf0);
    wr(8'h0c, 8'hff);
    wr(8'h04, 8'h09);
    wr(8'h10, 8'h03);
    chk("irq", 1'h0, irq);
    wr(8'h00, 8'h40);
    repeat (20) @(posedge aclk);
    chk("irq", 1'h1, irq);
    wr(8'h10, 8'h01);
    chk("irq", 1'h0, irq);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    // Software timer on module 1
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h30, 8'h49);
    wr(8'h34, 8'h05);
    rd(8'h30, 8'h09);
    wr(8'h38, 8'h01);
    rd(8'h30, 8'h49);
    wr(8'h10, 8'h03);
    chk("line drive", 5'h02, module_line_oe);
    wr(8'h00, 8'h40);
    repeat (12) @(posedge aclk);
    rd(8'h00, 8'h42);
    chk("irq", 1'h1, irq);
    wr(8'h00, 8'h40);
    chk("irq", 1'h0, irq);
    complete_run();
  end
endmodule
`default_nettype wire
